// [msqr_responder.v]
// status query responder: snapshots status into a buffer and streams reply bytes
`timescale 1ns/1ps
`default_nettype none
`include "msqr_consts.vh"

module msqr_responder (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rstn,
    // query command
    input  wire        i_cmd_valid,
    input  wire [15:0] i_cmd_opcode,
    output wire        o_cmd_ready,
    output reg         o_cmd_reject,
    // reply byte stream
    output wire        o_rsp_valid,
    output wire [7:0]  o_rsp_data,
    output reg         o_rsp_last,
    input  wire        i_rsp_ready,
    output wire        o_busy,
    // earlier current-alarm bytes, passed as given
    input  wire [7:0]  i_mod_alarm1,
    input  wire [7:0]  i_mod_alarm2,
    input  wire [7:0]  i_drop_status,
    input  wire [7:0]  i_dmd_alarm1,
    // demod byte 2 sources
    input  wire        i_buf_underflow,
    input  wire        i_buf_overflow,
    input  wire        i_buf_below_low,
    input  wire        i_buf_above_high,
    input  wire        i_rs_lock_fault,
    input  wire        i_rs_deint_fault,
    input  wire        i_rs_uncorr_word,
    input  wire        i_dmd_summary_fault,
    // demod byte 3 sources
    input  wire        i_rx_synth_lock,
    input  wire        i_bufclk_pll_lock,
    input  wire        i_viterbi_lock,
    input  wire        i_seq_dec_lock,
    input  wire        i_rx_pattern_lock,
    input  wire        i_ext_ref_pll_lock,
    // demod byte 4 sources
    input  wire        i_act_buf_clk,
    input  wire        i_act_ext_coax,
    input  wire        i_act_rx_sat_clk,
    input  wire        i_act_insert_clk,
    input  wire        i_act_ext_ref,
    input  wire        i_act_hs_ref_pll,
    input  wire        i_rx_clk_fallback,
    input  wire        i_low_energy_per_bit_to_noise,
    // insert status sources
    input  wire        i_ins_frame_fault,
    input  wire        i_ins_mframe_fault,
    input  wire        i_ins_crc_fault,
    input  wire        i_mframe_mode,
    input  wire        i_crc_mode,
    // common supply monitors
    input  wire        i_neg12_fail,
    input  wire        i_pos12_fail,
    input  wire        i_pos5_fail,
    // mod byte 3 and 4 sources
    input  wire [3:0]  i_bwd_alarm_tx,
    input  wire        i_buc_dc_current_fail,
    input  wire        i_buc_dc_voltage_fail,
    input  wire        i_mod_wan_fail,
    // demod byte 5 and 6 sources
    input  wire        i_trellis_lock,
    input  wire        i_sig_fault,
    input  wire        i_turbo_fault,
    input  wire        i_dvb_frame_fault,
    input  wire        i_lnb_dc_current_fail,
    input  wire        i_lnb_dc_voltage_fail,
    input  wire        i_dmd_wan_fail,
    // link quality
    input  wire [15:0] i_raw_err_mant,
    input  wire [15:0] i_cor_err_mant,
    input  wire [15:0] i_energy_per_bit_to_noise,
    input  wire [7:0]  i_raw_err_exp,
    input  wire [7:0]  i_cor_err_exp,
    input  wire        i_err_valid,
    input  wire        i_test_err_valid,
    input  wire [1:0]  i_energy_per_bit_to_noise_state,
    input  wire        i_err_cnt_ovf,
    input  wire        i_test_err_cnt_ovf,
    input  wire [7:0]  i_input_level,
    // time of day
    input  wire [4:0]  i_hour,
    input  wire [5:0]  i_minute,
    input  wire [5:0]  i_second
);

    // out-of-range time inputs saturate so the reply never leaves its range
    function [5:0] msqr_clamp;
        input [5:0] val;
        input [5:0] lim;
        begin
            msqr_clamp = (val > lim) ? lim : val;
        end
    endfunction

    // true while the index sits on the final byte of the reply in hand
    function msqr_is_final;
        input [3:0] idx;
        input [3:0] len;
        begin
            msqr_is_final = (idx == len - 4'h1);
        end
    endfunction

    // controller states
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_LOAD  = 2'h1;
    localparam [1:0] ST_FETCH = 2'h2;
    localparam [1:0] ST_SHOW  = 2'h3;

    // reply kinds, chosen by the opcode and held for the whole reply
    localparam [1:0] KIND_ALARM = 2'h0;
    localparam [1:0] KIND_LINK  = 2'h1;
    localparam [1:0] KIND_TIME  = 2'h2;

    reg  [1:0] state_q;
    reg  [1:0] state_d;
    reg  [1:0] kind_q;
    reg  [1:0] kind_d;
    reg  [3:0] idx_q;
    reg  [3:0] idx_d;
    reg  [3:0] len_q;
    reg  [3:0] len_d;
    reg        last_d;
    reg        reject_d;
    reg  [7:0] load_byte;
    wire       wr_en;
    wire       rd_en;
    wire       accept;
    wire       hs;

    // assembled status bytes, reserved and spare positions held at zero
    wire [7:0] dmd_alarm2;
    wire [7:0] dmd_alarm3;
    wire [7:0] dmd_alarm4;
    wire [7:0] ins_status;
    wire [7:0] com_alarm1;
    wire [7:0] com_alarm2;
    wire [7:0] mod_alarm3;
    wire [7:0] mod_alarm4;
    wire [7:0] dmd_alarm5;
    wire [7:0] dmd_alarm6;
    reg  [7:0] lq_status;

    assign dmd_alarm2 = {i_dmd_summary_fault, i_rs_uncorr_word, i_rs_deint_fault,
                         i_rs_lock_fault, i_buf_above_high, i_buf_below_low,
                         i_buf_overflow, i_buf_underflow};
    assign dmd_alarm3 = {1'b0, i_ext_ref_pll_lock, i_rx_pattern_lock, i_seq_dec_lock,
                         i_viterbi_lock, i_bufclk_pll_lock, 1'b0,
                         i_rx_synth_lock};
    assign dmd_alarm4 = {i_low_energy_per_bit_to_noise, i_rx_clk_fallback,
                         i_act_hs_ref_pll, i_act_ext_ref, i_act_insert_clk,
                         i_act_rx_sat_clk, i_act_ext_coax, i_act_buf_clk};
    // multiframe and CRC faults mean nothing outside their framing modes
    assign ins_status = {5'h00, i_ins_crc_fault & i_crc_mode,
                         i_ins_mframe_fault & i_mframe_mode,
                         i_ins_frame_fault};
    assign com_alarm1 = {5'h00, i_pos5_fail, i_pos12_fail, i_neg12_fail};
    assign com_alarm2 = `MSQR_BYTE_RST;
    assign mod_alarm3 = {4'h0, i_bwd_alarm_tx};
    assign mod_alarm4 = {5'h00, i_mod_wan_fail, i_buc_dc_voltage_fail,
                         i_buc_dc_current_fail};
    assign dmd_alarm5 = {1'b0, i_dvb_frame_fault, 2'h0, i_turbo_fault, i_sig_fault,
                         1'b0, i_trellis_lock};
    assign dmd_alarm6 = {5'h00, i_dmd_wan_fail, i_lnb_dc_voltage_fail,
                         i_lnb_dc_current_fail};

    always @* begin
        lq_status = `MSQR_BYTE_RST;
        lq_status[`MSQR_LQ_ERR_VALID]  = i_err_valid;
        lq_status[`MSQR_LQ_TEST_VALID] = i_test_err_valid;
        lq_status[`MSQR_LQ_EBN_HI:`MSQR_LQ_EBN_LO] = i_energy_per_bit_to_noise_state;
        lq_status[`MSQR_LQ_ERR_OVF]    = i_err_cnt_ovf;
        lq_status[`MSQR_LQ_TEST_OVF]   = i_test_err_cnt_ovf;
    end

    // byte presented to the buffer at each load index; multi-byte fields go high byte first
    always @* begin
        load_byte = `MSQR_BYTE_RST;
        case (kind_q)
            KIND_ALARM: begin
                case (idx_q)
                    4'h0:    load_byte = i_mod_alarm1;
                    4'h1:    load_byte = i_mod_alarm2;
                    4'h2:    load_byte = i_drop_status;
                    4'h3:    load_byte = i_dmd_alarm1;
                    4'h4:    load_byte = dmd_alarm2;
                    4'h5:    load_byte = dmd_alarm3;
                    4'h6:    load_byte = dmd_alarm4;
                    4'h7:    load_byte = ins_status;
                    4'h8:    load_byte = com_alarm1;
                    4'h9:    load_byte = com_alarm2;
                    4'ha:    load_byte = mod_alarm3;
                    4'hb:    load_byte = mod_alarm4;
                    4'hc:    load_byte = dmd_alarm5;
                    4'hd:    load_byte = dmd_alarm6;
                    default: load_byte = `MSQR_BYTE_RST;
                endcase
            end
            KIND_LINK: begin
                case (idx_q)
                    4'h0:    load_byte = i_raw_err_mant[15:8];
                    4'h1:    load_byte = i_raw_err_mant[7:0];
                    4'h2:    load_byte = i_cor_err_mant[15:8];
                    4'h3:    load_byte = i_cor_err_mant[7:0];
                    4'h4:    load_byte = i_energy_per_bit_to_noise[15:8];
                    4'h5:    load_byte = i_energy_per_bit_to_noise[7:0];
                    4'h6:    load_byte = i_raw_err_exp;
                    4'h7:    load_byte = i_cor_err_exp;
                    4'h8:    load_byte = lq_status;
                    4'h9:    load_byte = i_input_level;
                    default: load_byte = `MSQR_BYTE_RST;
                endcase
            end
            KIND_TIME: begin
                case (idx_q)
                    4'h0:    load_byte = {2'h0, msqr_clamp({1'b0, i_hour}, `MSQR_HOUR_MAX)};
                    4'h1:    load_byte = {2'h0, msqr_clamp(i_minute, `MSQR_MIN_MAX)};
                    4'h2:    load_byte = {2'h0, msqr_clamp(i_second, `MSQR_MIN_MAX)};
                    default: load_byte = `MSQR_BYTE_RST;
                endcase
            end
            default: load_byte = `MSQR_BYTE_RST;
        endcase
    end

    // ready only in idle, so a query never overlaps a reply still in flight
    assign o_cmd_ready = (state_q == ST_IDLE);
    assign accept      = i_cmd_valid & o_cmd_ready;
    assign o_rsp_valid = (state_q == ST_SHOW);
    assign hs          = o_rsp_valid & i_rsp_ready;
    assign o_busy      = ~o_cmd_ready;
    assign wr_en       = (state_q == ST_LOAD);
    assign rd_en       = (state_q == ST_FETCH);

    // the whole reply is captured before the first byte leaves, so a slow host
    // cannot see fields from different moments mixed across a long stall;
    // the limit is that capture itself spans one cycle per byte
    always @* begin
        state_d  = state_q;
        kind_d   = kind_q;
        idx_d    = idx_q;
        len_d    = len_q;
        last_d   = o_rsp_last;
        reject_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                idx_d = 4'h0;
                if (accept) begin
                    case (i_cmd_opcode)
                        `MSQR_OP_ALARM: begin
                            kind_d  = KIND_ALARM;
                            len_d   = `MSQR_LEN_ALARM;
                            state_d = ST_LOAD;
                        end
                        `MSQR_OP_LINK: begin
                            kind_d  = KIND_LINK;
                            len_d   = `MSQR_LEN_LINK;
                            state_d = ST_LOAD;
                        end
                        `MSQR_OP_TIME: begin
                            kind_d  = KIND_TIME;
                            len_d   = `MSQR_LEN_TIME;
                            state_d = ST_LOAD;
                        end
                        default: begin
                            // dropped at once; the one-cycle pulse is its only trace
                            reject_d = 1'b1;
                        end
                    endcase
                end
            end
            ST_LOAD: begin
                // status is sampled one byte per cycle while loading
                if (msqr_is_final(idx_q, len_q)) begin
                    idx_d   = 4'h0;
                    state_d = ST_FETCH;
                end else begin
                    idx_d = idx_q + 4'h1;
                end
            end
            ST_FETCH: begin
                last_d  = msqr_is_final(idx_q, len_q);
                state_d = ST_SHOW;
            end
            ST_SHOW: begin
                // a stalled host keeps us here; byte and last flag stay put
                if (hs) begin
                    if (o_rsp_last) begin
                        idx_d   = 4'h0;
                        last_d  = 1'b0;
                        state_d = ST_IDLE;
                    end else begin
                        idx_d   = idx_q + 4'h1;
                        state_d = ST_FETCH;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q      <= ST_IDLE;
            kind_q       <= 2'h0;
            idx_q        <= 4'h0;
            len_q        <= 4'h0;
            o_rsp_last   <= 1'b0;
            o_cmd_reject <= 1'b0;
        end else begin
            state_q      <= state_d;
            kind_q       <= kind_d;
            idx_q        <= idx_d;
            len_q        <= len_d;
            o_rsp_last   <= last_d;
            o_cmd_reject <= reject_d;
        end
    end

    // read and write share the index, so bytes leave in capture order
    msqr_reply_mem u_buf (
        .i_clk     (i_clk),
        .i_wr_en   (wr_en),
        .i_wr_addr (idx_q),
        .i_wr_data (load_byte),
        .i_rd_en   (rd_en),
        .i_rd_addr (idx_q),
        .o_rd_data (o_rsp_data)
    );

endmodule // msqr_responder

`default_nettype wire

// [msqr_consts.vh]
// constants shared by the modem status query responder
//
// Behaviour
// - current-alarm query returns live alarm bytes in fixed order after mod/drop bytes.
// - demod byte 2: buffer flags, RS faults, demod summary fault; one means failing.
// - demod byte 3: lock indicators, one means locked; bits 1 and 7 reserved.
// - demod byte 4: six activity bits, receive clock fallback, low energy-per-bit.
// - insert byte: frame, multiframe, CRC lock faults; mode-dependent bits; rest reserved.
// - common byte 1: minus 12 V, plus 12 V, plus 5 V supply failures.
// - mod byte 3: backward alarms 1 to 4 being transmitted; upper bits spare.
// - mod byte 4: upconverter DC current, DC voltage, Ethernet WAN alarms.
// - demod byte 5: trellis lock, signaling, turbo and DVB frame lock faults.
// - demod byte 6: low-noise block DC current, DC voltage, Ethernet WAN alarms.
// - link-quality reply order: raw, corrected mantissas, energy per bit, exponents, status, level.
// - each error-rate mantissa is a two-byte unsigned binary field.
// - energy per bit to noise is two bytes, one count per tenth of a decibel.
// - each error-rate exponent is one unsigned byte after the Eb/No field.
// - status bit 0 error figures valid, bit 1 test-pattern rate valid.
// - status bits 2-3 encode energy-per-bit validity: invalid, valid, below, above.
// - status bit 4 error counter overflow, bit 5 test counter overflow.
// - last link-quality byte is input level, one decibel per step.
// - time query returns hour 0-23, minute 0-59, second 0-59.
`ifndef MSQR_CONSTS_VH
`define MSQR_CONSTS_VH

// query opcodes
`define MSQR_OP_ALARM       16'h240a
`define MSQR_OP_LINK        16'h240d
`define MSQR_OP_TIME        16'h240e

// reply lengths in bytes
`define MSQR_LEN_ALARM      4'he
`define MSQR_LEN_LINK       4'ha
`define MSQR_LEN_TIME       4'h3

// reply buffer depth and reset value of a byte
`define MSQR_BUF_DEPTH      16
`define MSQR_BYTE_RST       8'h00

// link-quality status byte fields
`define MSQR_LQ_ERR_VALID   0
`define MSQR_LQ_TEST_VALID  1
`define MSQR_LQ_EBN_LO      2
`define MSQR_LQ_EBN_HI      3
`define MSQR_LQ_ERR_OVF     4
`define MSQR_LQ_TEST_OVF    5

// time field limits
`define MSQR_HOUR_MAX       6'h17
`define MSQR_MIN_MAX        6'h3b

`endif

// [msqr_reply_mem.v]
// reply byte buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "msqr_consts.vh"

module msqr_reply_mem (
    // clock
    input  wire       i_clk,
    // write side
    input  wire       i_wr_en,
    input  wire [3:0] i_wr_addr,
    input  wire [7:0] i_wr_data,
    // read side
    input  wire       i_rd_en,
    input  wire [3:0] i_rd_addr,
    output reg  [7:0] o_rd_data
);

    reg [7:0] mem [0:`MSQR_BUF_DEPTH-1];

    // no reset on the array; only bytes written for the current reply are read
    always @(posedge i_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        if (i_rd_en) begin
            o_rd_data <= mem[i_rd_addr];
        end
    end

endmodule // msqr_reply_mem

`default_nettype wire

// [msqr_responder_properties.sv]
// checker for the status query responder command and reply handshakes
`timescale 1ns/1ps
`default_nettype none
`include "msqr_consts.vh"

module msqr_responder_checker (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_rstn,
    // command and reply ports
    input wire logic        i_cmd_valid,
    input wire logic [15:0] i_cmd_opcode,
    input wire logic        o_cmd_ready,
    input wire logic        o_cmd_reject,
    input wire logic        o_rsp_valid,
    input wire logic [7:0]  o_rsp_data,
    input wire logic        o_rsp_last,
    input wire logic        i_rsp_ready,
    input wire logic        o_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    logic take;
    logic known;
    logic hshk;
    assign take  = i_cmd_valid && o_cmd_ready;
    assign known = (i_cmd_opcode == `MSQR_OP_ALARM) || (i_cmd_opcode == `MSQR_OP_LINK) ||
                   (i_cmd_opcode == `MSQR_OP_TIME);
    assign hshk  = o_rsp_valid && i_rsp_ready;

    a_busy_inverse: assert property (o_busy == !o_cmd_ready)
        else $error("busy is not the inverse of ready");
    a_reject_unknown: assert property (take && !known |=> o_cmd_reject && o_cmd_ready)
        else $error("unknown opcode not rejected");
    a_accept_known: assert property (take && known |=> !o_cmd_ready && !o_cmd_reject)
        else $error("known opcode not accepted");
    a_alarm_start: assert property (take && i_cmd_opcode == `MSQR_OP_ALARM |->
        ##16 o_rsp_valid)
        else $error("alarm reply late");
    a_link_start: assert property (take && i_cmd_opcode == `MSQR_OP_LINK |->
        ##12 o_rsp_valid)
        else $error("link reply late");
    a_time_start: assert property (take && i_cmd_opcode == `MSQR_OP_TIME |->
        ##5 o_rsp_valid)
        else $error("time reply late");
    a_stall_hold: assert property (o_rsp_valid && !i_rsp_ready |=>
        o_rsp_valid && $stable(o_rsp_data) && $stable(o_rsp_last))
        else $error("reply byte changed while stalled");
    a_fetch_gap: assert property (hshk && !o_rsp_last |=> !o_rsp_valid ##1 o_rsp_valid)
        else $error("next reply byte not after one fetch cycle");
    a_last_release: assert property (hshk && o_rsp_last |=> o_cmd_ready && !o_rsp_valid)
        else $error("idle not resumed after last byte");
    a_idle_quiet: assert property (o_cmd_ready |-> !o_rsp_valid && !o_rsp_last)
        else $error("reply byte shown while idle");

    c_alarm_taken: cover property (take && i_cmd_opcode == `MSQR_OP_ALARM);
    c_reject: cover property (o_cmd_reject);
    c_stall: cover property (o_rsp_valid && !i_rsp_ready ##1 hshk);
endmodule // msqr_responder_checker

bind msqr_responder msqr_responder_checker i_msqr_responder_checker (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_cmd_valid(i_cmd_valid), .i_cmd_opcode(i_cmd_opcode),
    .o_cmd_ready(o_cmd_ready), .o_cmd_reject(o_cmd_reject), .o_rsp_valid(o_rsp_valid),
    .o_rsp_data(o_rsp_data), .o_rsp_last(o_rsp_last), .i_rsp_ready(i_rsp_ready),
    .o_busy(o_busy)
);
`default_nettype wire

// [msqr_host_model.sv]
// remote host taking reply bytes, promptly or with random stalls
`timescale 1ns/1ps
`default_nettype none

module msqr_host_model (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // pacing
    input  wire logic i_slow,
    output var  logic o_rsp_ready
);
    // a slow host takes about one cycle in four, so held bytes get exercised
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rsp_ready <= 1'b0;
        end else begin
            o_rsp_ready <= !i_slow || ($urandom % 4 == 0);
        end
    end
endmodule // msqr_host_model
`default_nettype wire

// [msqr_responder_bench.sv]
// self-checking bench for the status query responder
`timescale 1ns/1ps
`default_nettype none
`include "msqr_consts.vh"

module msqr_responder_bench;
    logic        clk = 1'b0, rstn = 1'b0, cv = 1'b0, slow = 1'b0;
    logic [15:0] opc = 16'h0000;
    logic [7:0]  m1 = '0, m2 = '0, dr = '0, d1 = '0, a2 = '0, a4 = '0, rexp = '0, cexp = '0;
    logic [7:0]  lvl = '0;
    logic [6:0]  a3 = '0;
    logic [4:0]  ins = '0, hr = '0;
    logic [3:0]  bwd = '0, d5 = '0;
    logic [2:0]  com = '0, m4 = '0, d6 = '0;
    logic [15:0] raw = '0, cor = '0, ebn = '0;
    logic [5:0]  fl = '0, mi = '0, se = '0;
    wire logic       crdy, rej, vld, lst, busy, rdy;
    wire logic [7:0] dat;
    logic [8:0]  q [$];
    logic [15:0] ops [5];
    logic [191:0] rnd;
    int          errors = 0, compares = 0, i, k;

    always #10 clk = ~clk;

    msqr_responder i_msqr_responder (
        .i_clk(clk), .i_rstn(rstn), .i_cmd_valid(cv), .i_cmd_opcode(opc),
        .o_cmd_ready(crdy), .o_cmd_reject(rej), .o_rsp_valid(vld), .o_rsp_data(dat),
        .o_rsp_last(lst), .i_rsp_ready(rdy), .o_busy(busy),
        .i_mod_alarm1(m1), .i_mod_alarm2(m2), .i_drop_status(dr), .i_dmd_alarm1(d1),
        .i_buf_underflow(a2[0]), .i_buf_overflow(a2[1]), .i_buf_below_low(a2[2]),
        .i_buf_above_high(a2[3]), .i_rs_lock_fault(a2[4]), .i_rs_deint_fault(a2[5]),
        .i_rs_uncorr_word(a2[6]), .i_dmd_summary_fault(a2[7]),
        .i_rx_synth_lock(a3[0]), .i_bufclk_pll_lock(a3[2]), .i_viterbi_lock(a3[3]),
        .i_seq_dec_lock(a3[4]), .i_rx_pattern_lock(a3[5]), .i_ext_ref_pll_lock(a3[6]),
        .i_act_buf_clk(a4[0]), .i_act_ext_coax(a4[1]), .i_act_rx_sat_clk(a4[2]),
        .i_act_insert_clk(a4[3]), .i_act_ext_ref(a4[4]), .i_act_hs_ref_pll(a4[5]),
        .i_rx_clk_fallback(a4[6]), .i_low_energy_per_bit_to_noise(a4[7]),
        .i_ins_frame_fault(ins[0]), .i_ins_mframe_fault(ins[1]), .i_ins_crc_fault(ins[2]),
        .i_mframe_mode(ins[3]), .i_crc_mode(ins[4]),
        .i_neg12_fail(com[0]), .i_pos12_fail(com[1]), .i_pos5_fail(com[2]),
        .i_bwd_alarm_tx(bwd), .i_buc_dc_current_fail(m4[0]), .i_buc_dc_voltage_fail(m4[1]),
        .i_mod_wan_fail(m4[2]), .i_trellis_lock(d5[0]), .i_sig_fault(d5[1]),
        .i_turbo_fault(d5[2]), .i_dvb_frame_fault(d5[3]), .i_lnb_dc_current_fail(d6[0]),
        .i_lnb_dc_voltage_fail(d6[1]), .i_dmd_wan_fail(d6[2]),
        .i_raw_err_mant(raw), .i_cor_err_mant(cor), .i_energy_per_bit_to_noise(ebn),
        .i_raw_err_exp(rexp), .i_cor_err_exp(cexp), .i_err_valid(fl[0]),
        .i_test_err_valid(fl[1]), .i_energy_per_bit_to_noise_state(fl[3:2]),
        .i_err_cnt_ovf(fl[4]), .i_test_err_cnt_ovf(fl[5]), .i_input_level(lvl),
        .i_hour(hr), .i_minute(mi), .i_second(se)
    );

    msqr_host_model i_msqr_host_model (
        .i_clk(clk), .i_rstn(rstn), .i_slow(slow), .o_rsp_ready(rdy)
    );

    task automatic results();
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp_rsp(input logic [8:0] e, input logic [8:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] rsp_byte expected %h seen %h", e, g);
        end
    endtask

    task automatic cmp_flag(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic put(input logic [7:0] b, input logic l);
        q.push_back({l, b});
    endtask

    task automatic push_exp(input logic [15:0] op);
        if (op == `MSQR_OP_ALARM) begin
            put(m1, 1'b0);
            put(m2, 1'b0);
            put(dr, 1'b0);
            put(d1, 1'b0);
            put(a2, 1'b0);
            put({1'b0, a3[6:2], 1'b0, a3[0]}, 1'b0);
            put(a4, 1'b0);
            put({5'h00, ins[2] & ins[4], ins[1] & ins[3], ins[0]}, 1'b0);
            put({5'h00, com}, 1'b0);
            put(8'h00, 1'b0);
            put({4'h0, bwd}, 1'b0);
            put({5'h00, m4}, 1'b0);
            put({1'b0, d5[3], 2'b00, d5[2], d5[1], 1'b0, d5[0]}, 1'b0);
            put({5'h00, d6}, 1'b1);
        end else if (op == `MSQR_OP_LINK) begin
            put(raw[15:8], 1'b0);
            put(raw[7:0], 1'b0);
            put(cor[15:8], 1'b0);
            put(cor[7:0], 1'b0);
            put(ebn[15:8], 1'b0);
            put(ebn[7:0], 1'b0);
            put(rexp, 1'b0);
            put(cexp, 1'b0);
            put({2'b00, fl}, 1'b0);
            put(lvl, 1'b1);
        end else if (op == `MSQR_OP_TIME) begin
            put({2'b00, ({1'b0, hr} > `MSQR_HOUR_MAX) ? `MSQR_HOUR_MAX : {1'b0, hr}}, 1'b0);
            put({2'b00, (mi > `MSQR_MIN_MAX) ? `MSQR_MIN_MAX : mi}, 1'b0);
            put({2'b00, (se > `MSQR_MIN_MAX) ? `MSQR_MIN_MAX : se}, 1'b1);
        end
    endtask

    // one query at a time: the bench only asks when the responder is idle
    task automatic query(input logic [15:0] op);
        int  n;
        logic kn;
        kn = (op == `MSQR_OP_ALARM) || (op == `MSQR_OP_LINK) || (op == `MSQR_OP_TIME);
        @(posedge clk);
        push_exp(op);
        cv  <= 1'b1;
        opc <= op;
        @(posedge clk);
        cv  <= 1'b0;
        @(negedge clk);
        cmp_flag("cmd_reject", !kn, rej);
        cmp_flag("busy", kn, busy);
        for (n = 0; n < 400 && !(q.size() == 0 && crdy === 1'b1); n++) @(negedge clk);
        if (n == 400) begin
            errors++;
            $display("[FAIL] reply_end expected done seen %0d left", q.size());
            results();
        end
    endtask

    always @(posedge clk) begin
        if (rstn === 1'b1 && vld === 1'b1 && rdy === 1'b1) begin
            if (q.size() == 0) begin
                errors++;
                $display("[FAIL] rsp_byte expected none seen %h", dat);
            end else begin
                cmp_rsp(q.pop_front(), {lst, dat});
            end
        end
    end

    initial begin
        ops = '{`MSQR_OP_ALARM, `MSQR_OP_LINK, `MSQR_OP_TIME, 16'h240b, 16'h240f};
        void'($urandom(32'hd707be4a));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        for (i = 0; i < 60; i++) begin
            @(posedge clk);
            rnd = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
            {m1, m2, dr, d1, a2, a3, a4, ins, com, bwd, m4, d5, d6, raw, cor, ebn,
             rexp, cexp, fl, lvl, hr, mi, se} <= rnd[167:0];
            slow <= i[0];
            k = (i < 10) ? i % 5 : $urandom % 5;
            query(ops[k]);
        end
        results();
    end
endmodule // msqr_responder_bench
`default_nettype wire
